/* tb/pae_src_model.sv */
`default_nettype none
module pae_src_model (
  input wire logic                                  pclk,
  input wire logic [2:0]                            step,
  input wire logic                                  ack_req,
  output logic [pae_pkg::NCH*pae_pkg::VW-1:0]       measured_process_value,
  output logic [pae_pkg::NCH*pae_pkg::VW-1:0]       reference_value,
  output logic                                      ack_button
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] PV_TAB [5][6] = '{
    '{16'h0032, 16'hFF6A, 16'h0014, 16'h001E, 16'h001E, 16'h0032},
    '{16'h0078, 16'h0000, 16'h0032, 16'h0000, 16'h0000, 16'h0096},
    '{16'h005F, 16'hFF6A, 16'h0029, 16'h000B, 16'h0037, 16'h0096},
    '{16'h0055, 16'h0000, 16'h0028, 16'h000A, 16'h0032, 16'h0032},
    '{16'h0055, 16'h0000, 16'h0028, 16'h000A, 16'h0032, 16'h0032}};
  logic [3:0] hold_r = 4'h0;
  always_comb begin
    measured_process_value = '0;
    for (int i = 0; i < 6; i++) begin
      measured_process_value[i*16+:16] = PV_TAB[step][i];
    end
  end
  assign reference_value = (pae_pkg::NCH*pae_pkg::VW)'(
    {16'h001E, 16'h001E, 16'h0014, 32'h0});
  // The button is held for several cycles so the input filter sees a level.
  always @(posedge pclk) begin
    if (ack_req) hold_r <= 4'h8;
    else if (hold_r != 4'h0) hold_r <= hold_r - 4'h1;
  end
  assign ack_button = hold_r != 4'h0;
endmodule : pae_src_model
`default_nettype wire

/* tb/pae_top_checker.sv */
`default_nettype none
module pae_top_checker (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [pae_pkg::AW-1:0]      paddr,
  input wire logic [pae_pkg::DW-1:0]      prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        sample_strobe,
  input wire logic [pae_pkg::NCH-1:0]     alarm_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // Cycles since the last strobe; an alarm may only move during a pass.
  logic [5:0] since_r;
  logic       en_wr_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since_r <= 6'h3F;
    else if (sample_strobe) since_r <= 6'h00;
    else if (since_r != 6'h3F) since_r <= since_r + 6'h01;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) en_wr_r <= 1'b0;
    else if (pready && pwrite && paddr == pae_pkg::ADDR_ENABLE)
      en_wr_r <= 1'b1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  AST_RESET_QUIET: assert property (
    $rose(presetn) |-> alarm_out == '0 && !pready)
    else $error("outputs busy after reset");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_DATA_IDLE_ZERO: assert property (!pready |-> prdata == '0)
    else $error("prdata not zero outside answer");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  AST_ACCESS_ANSWERED: assert property (
    s_setup ##1 s_access |-> ##[1:60] pready)
    else $error("access phase not answered");
  AST_STATUS_MIRROR: assert property (
    pready && !pwrite && paddr == pae_pkg::ADDR_STATUS
    |-> prdata == 32'(alarm_out))
    else $error("status read differs from alarm outputs");
  AST_ENABLE_RESET: assert property (
    pready && !pwrite && paddr == pae_pkg::ADDR_ENABLE && !en_wr_r
    |-> prdata == 32'(pae_pkg::ENABLE_RST))
    else $error("enable reset value wrong");
  AST_ONE_CHANNEL_STEP: assert property (
    $onehot0(alarm_out ^ $past(alarm_out)))
    else $error("two alarms changed in one cycle");
  AST_ALARM_AFTER_SAMPLE: assert property (
    $changed(alarm_out) |-> since_r <= 6'h32)
    else $error("alarm changed without a sample");
endmodule : pae_top_checker
bind pae_top pae_top_checker chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .sample_strobe, .alarm_out);
`default_nettype wire

/* tb/process_alarm_evaluator_test.sv */
`default_nettype none
module process_alarm_evaluator_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        sample_strobe = 0, ack_req = 0, pready, pslverr, er, ack_button;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [367:0] mpv, refv;
  logic [22:0] alarm_out;
  logic [2:0]  step = '0;
  logic        ack_dig = 0;
  int          fails = 0, num_checks = 0;
  localparam logic [31:0] CFG_LO [6] = '{32'h000A0064, 32'h0000FF9C,
    32'h00000014, 32'h00000014, 32'h00000014, 32'h00000064};
  localparam logic [31:0] CFG_HI [6] = '{32'h1, 32'h22, 32'h3, 32'h4,
    32'h5, 32'h11};
  localparam logic [2:0]  SEQ [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h1,
    3'h3, 3'h4};
  localparam logic [31:0] EXP [8] = '{32'h0, 32'h3D, 32'h37, 32'h20, 32'h0,
    32'h3D, 32'h20, 32'h0};
  initial forever #2.5 pclk = ~pclk;
  pae_src_model src (.pclk(pclk), .step(step), .ack_req(ack_req),
    .measured_process_value(mpv), .reference_value(refv),
    .ack_button(ack_button));
  pae_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_strobe(sample_strobe),
    .measured_process_value(mpv), .reference_value(refv),
    .ack_button(ack_button), .ack_input(ack_dig), .alarm_out(alarm_out));
  //////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 200);
    if (n >= 200) begin
      fails++;
      summarize();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, pae_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, pae_pkg::ADDR_ENABLE, 32'h0);
    chk(rd, 32'(pae_pkg::ENABLE_RST));
    apb(1'b0, 12'hFFC, 32'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    $display("test reset done");
    for (int ch = 0; ch < 6; ch++) begin
      apb(1'b1, pae_pkg::ADDR_CFG_BASE + 12'(ch * 8), CFG_LO[ch]);
      apb(1'b1, pae_pkg::ADDR_CFG_BASE + 12'(ch * 8 + 4), CFG_HI[ch]);
    end
    apb(1'b0, pae_pkg::ADDR_CFG_BASE + 12'h004, 32'h0);
    chk(rd, CFG_HI[0]);
    $display("test config done");
    // Ack by register lands while the manual channel is still tripped.
    // The second round trips it again and acks through the digital input.
    for (int s = 0; s < 8; s++) begin
      step <= SEQ[s];
      if (s == 2) apb(1'b1, pae_pkg::ADDR_ACK, 32'h20);
      if (s == 4) begin
        @(posedge pclk);
        ack_req <= 1'b1;
        @(posedge pclk);
        ack_req <= 1'b0;
        repeat (12) @(posedge pclk);
      end
      if (s == 7) begin
        ack_dig <= 1'b1;
        repeat (8) @(posedge pclk);
        ack_dig <= 1'b0;
        repeat (8) @(posedge pclk);
      end
      @(posedge pclk);
      sample_strobe <= 1'b1;
      @(posedge pclk);
      sample_strobe <= 1'b0;
      repeat (60) @(posedge pclk);
      apb(1'b0, pae_pkg::ADDR_STATUS, 32'h0);
      chk(rd, EXP[s]);
      chk(32'(alarm_out), EXP[s]);
      if (s == 0) begin
        apb(1'b0, pae_pkg::ADDR_ARMED, 32'h0);
        chk(rd, 32'h3D);
      end
    end
    $display("test alarms done");
    apb(1'b1, pae_pkg::ADDR_ENABLE, 32'h007FFFFF);
    apb(1'b0, pae_pkg::ADDR_ENABLE, 32'h0);
    chk(rd, 32'h007FFFFF);
    $display("test enable done");
    summarize();
  end
endmodule : process_alarm_evaluator_test
`default_nettype wire

/* verilog/pae_cfg_if.sv */
`default_nettype none
interface pae_cfg_if;
  logic                          we_lo;
  logic                          we_hi;
  logic [pae_pkg::CHW-1:0]       waddr;
  logic [pae_pkg::DW-1:0]        wdata;
  logic [pae_pkg::CHW-1:0]       raddr;
  logic [pae_pkg::CFGW-1:0]      rdata;

  modport ctrl (output we_lo, output we_hi, output waddr, output wdata,
                output raddr, input rdata);
  modport ram  (input we_lo, input we_hi, input waddr, input wdata,
                input raddr, output rdata);
endinterface : pae_cfg_if
`default_nettype wire

/* verilog/pae_cfg_ram.sv */
`default_nettype none
module pae_cfg_ram (
  input wire logic clk,
  pae_cfg_if.ram   port
);

  logic [pae_pkg::CFGW-1:0] mem [0:pae_pkg::NCH-1];
  logic [pae_pkg::CFGW-1:0] rdata_r;

  // Contents are not reset; the controller masks halves never written.
  always_ff @(posedge clk) begin
    if (port.we_lo) begin
      mem[port.waddr][pae_pkg::DW-1:0] <= port.wdata;
    end
    if (port.we_hi) begin
      mem[port.waddr][pae_pkg::CFGW-1:pae_pkg::DW] <= port.wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata_r <= mem[port.raddr];
  end

  assign port.rdata = rdata_r;

endmodule : pae_cfg_ram
`default_nettype wire

/* verilog/pae_pkg.sv */
`default_nettype none
package pae_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Channel map. Loop 1..3 take two channels each, then the fixed PV
  // input, the fixed analogue input, module slots 1,3,4,5,6 and user.
  localparam int NUM_LOOPS     = 3;
  localparam int ALM_PER_LOOP  = 2;
  localparam int CH_LOOP_BASE  = 0;
  localparam int CH_PV_BASE    = 6;
  localparam int CH_AN_BASE    = 8;
  localparam int CH_MOD_BASE   = 10;
  localparam int NUM_MOD_CH    = 5;
  localparam int CH_USER_BASE  = 15;
  localparam int NUM_USER      = 8;
  localparam int NCH           = 23;
  localparam int CHW           = 5;

  localparam int VW            = 16;
  localparam int XW            = 18;
  localparam int DW            = 32;
  localparam int CFGW          = 64;
  localparam int AW            = 12;

  // Only the loop alarms are live on a fresh unit.
  localparam logic [NCH-1:0] ENABLE_RST = 23'h00003F;

  //////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses.
  localparam logic [AW-1:0] ADDR_ENABLE   = 12'h000;
  localparam logic [AW-1:0] ADDR_STATUS   = 12'h004;
  localparam logic [AW-1:0] ADDR_COND     = 12'h008;
  localparam logic [AW-1:0] ADDR_ACK      = 12'h00C;
  localparam logic [AW-1:0] ADDR_ARMED    = 12'h010;
  localparam logic [AW-1:0] ADDR_CFG_BASE = 12'h100;
  localparam logic [AW-1:0] ADDR_CFG_END  = 12'h1B8;
  localparam int            CFG_IDX_LSB   = 3;
  localparam int            CFG_HALF_BIT  = 2;

  // Configuration word fields, positions in the 64-bit entry.
  localparam int THR_LSB   = 0;
  localparam int HYST_LSB  = 16;
  localparam int TYPE_LSB  = 32;
  localparam int TYPE_W    = 3;
  localparam int LATCH_LSB = 35;
  localparam int LATCH_W   = 2;
  localparam int BLOCK_BIT = 37;
  localparam int DELAY_LSB = 48;

  // Rate is the change in value over four samples; this is the last span index.
  localparam int               SPAN_W         = 2;
  localparam logic [SPAN_W-1:0] RATE_SPAN_LAST = 2'h3;

  typedef enum logic [2:0] {
    PAE_OFF      = 3'h0,
    PAE_FS_HIGH  = 3'h1,
    PAE_FS_LOW   = 3'h2,
    PAE_DEV_HIGH = 3'h3,
    PAE_DEV_LOW  = 3'h4,
    PAE_DEV_BAND = 3'h5,
    PAE_ROC_NEG  = 3'h6,
    PAE_ROC_POS  = 3'h7
  } pae_type_t;

  typedef enum logic [1:0] {
    PAE_LATCH_NONE   = 2'h0,
    PAE_LATCH_AUTO   = 2'h1,
    PAE_LATCH_MANUAL = 2'h2,
    PAE_LATCH_EVENT  = 2'h3
  } pae_latch_t;

  typedef enum logic [4:0] {
    PAE_ST_IDLE  = 5'h01,
    PAE_ST_FETCH = 5'h02,
    PAE_ST_EVAL  = 5'h04,
    PAE_ST_BRD   = 5'h08,
    PAE_ST_BACK  = 5'h10
  } pae_state_t;

endpackage : pae_pkg
`default_nettype wire

/* verilog/pae_top.sv */
// The implementer's own choices: the APB interface to the registers and the register addresses.
`default_nettype none
// Functional notes
// - High alarm goes active when the value rises above the threshold.
// - Low alarm goes active when the value falls below the threshold.
// - Hysteresis separates the on level from the off level.
// - Deviation high: value minus setpoint positive beyond the threshold.
// - Deviation low: value minus setpoint negative beyond the threshold.
// - User channels take deviation as difference of their two inputs.
// - Deviation band: active when deviation is outside the band.
// - Falling rate alarm when value drops faster than the rate limit.
// - Rising rate alarm when value climbs faster than the rate limit.
// - Rate alarm holds while rate exceeds limit; measured over samples.
// - Rate alarms use hysteresis in rate units.
// - Blocking suppresses an alarm until its safe state is first seen.
// - Blocked high alarm starting high waits for a drop and a new rise.
// - Blocked high alarm starting low trips on the first rise.
// - Blocked low alarm arms after the safe state; next low trips it.
// - Blocked band alarm arms once safe; either side then trips it.
// - Latched alarms hold until acknowledged by button, input or bus.
// - Auto reset: clear when condition gone and ack seen, ack remembered.
// - Manual reset: only an ack after the condition has gone clears it.
// - Two alarms per loop; only loop alarms enabled after reset.
// - Fixed PV input and fixed analogue input have two alarms each.
// - Module alarms for slots 1,3,4,5,6; slot 2 has none.
// - Eight user alarms wired to any variable.
// - Alarm shown only after its condition outlasts the delay time.
module pae_top (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [pae_pkg::AW-1:0]              paddr,
  input  wire logic [pae_pkg::DW-1:0]              pwdata,
  output logic      [pae_pkg::DW-1:0]              prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire logic                                sample_strobe,
  input  wire logic [pae_pkg::NCH*pae_pkg::VW-1:0] measured_process_value,
  input  wire logic [pae_pkg::NCH*pae_pkg::VW-1:0] reference_value,
  input  wire logic                                ack_button,
  input  wire logic                                ack_input,
  output logic      [pae_pkg::NCH-1:0]             alarm_out
);

  localparam int NCH = pae_pkg::NCH;
  localparam int VW  = pae_pkg::VW;
  localparam int XW  = pae_pkg::XW;
  localparam int CHW = pae_pkg::CHW;
  localparam int DW  = pae_pkg::DW;

  //////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic signed [XW-1:0] sext(input logic [VW-1:0] a);
    sext = $signed({{(XW-VW){a[VW-1]}}, a});
  endfunction : sext

  // Once on, the level drops by the hysteresis before the alarm releases.
  function automatic logic above(input logic signed [XW-1:0] x,
                                 input logic signed [XW-1:0] lvl,
                                 input logic signed [XW-1:0] hy,
                                 input logic                 was);
    above = was ? (x > (lvl - hy)) : (x > lvl);
  endfunction : above

  function automatic logic is_cfg(input logic [pae_pkg::AW-1:0] a);
    is_cfg = (a >= pae_pkg::ADDR_CFG_BASE) && (a < pae_pkg::ADDR_CFG_END);
  endfunction : is_cfg

  function automatic logic [CHW-1:0] cfg_idx(input logic [pae_pkg::AW-1:0] a);
    logic [pae_pkg::AW-1:0] off;
    off     = a - pae_pkg::ADDR_CFG_BASE;
    cfg_idx = is_cfg(a) ? off[pae_pkg::CFG_IDX_LSB +: CHW] : '0;
  endfunction : cfg_idx

  function automatic logic addr_ok(input logic [pae_pkg::AW-1:0] a);
    addr_ok = (a[1:0] == 2'h0) &&
              (is_cfg(a) || a == pae_pkg::ADDR_ENABLE ||
               a == pae_pkg::ADDR_STATUS || a == pae_pkg::ADDR_COND ||
               a == pae_pkg::ADDR_ACK || a == pae_pkg::ADDR_ARMED);
  endfunction : addr_ok

  function automatic logic [DW-1:0] zext(input logic [NCH-1:0] v);
    zext = {{(DW-NCH){1'b0}}, v};
  endfunction : zext

  //////////////////////////////////////////////////////////////////////////
  // State.

  pae_pkg::pae_state_t st_r;
  logic [CHW-1:0]      ch_r;
  logic                sample_pend_r;
  logic [pae_pkg::SPAN_W-1:0] span_r;

  logic [NCH-1:0] enable_r;
  logic [NCH-1:0] raw_r;
  logic [NCH-1:0] armed_r;
  logic [NCH-1:0] cdel_r;
  logic [NCH-1:0] out_r;
  logic [NCH-1:0] pend_r;
  logic [NCH-1:0] man_r;
  logic [NCH-1:0] wlo_r;
  logic [NCH-1:0] whi_r;
  logic [VW-1:0]  cnt_r  [0:NCH-1];
  logic [VW-1:0]  snap_r [0:NCH-1];
  logic signed [XW-1:0] rate_r [0:NCH-1];

  logic [1:0]     sync1_r;
  logic [1:0]     sync2_r;
  logic [1:0]     sync3_r;
  logic [1:0]     filt_r;
  logic           pin_ack_r;

  logic [DW-1:0]  prdata_r;
  logic           pready_r;
  logic           pslverr_r;

  pae_cfg_if cfg_bus ();

  pae_cfg_ram u_cfg_ram (
    .clk  (pclk),
    .port (cfg_bus)
  );

  //////////////////////////////////////////////////////////////////////////
  // Bus decode and configuration port.

  logic           st_eval;
  logic           bus_commit;
  logic           cfg_wr;
  logic [CHW-1:0] sel_idx;
  logic [pae_pkg::CFGW-1:0] cfg;
  logic [NCH-1:0] ack_now;
  logic [NCH-1:0] cap_ok;

  assign st_eval    = (st_r == pae_pkg::PAE_ST_EVAL);
  assign bus_commit = (st_r == pae_pkg::PAE_ST_BACK) && pwrite && !pslverr_r;
  assign cfg_wr     = bus_commit && is_cfg(paddr);
  assign sel_idx    = st_eval ? ch_r : cfg_idx(paddr);

  assign cfg_bus.we_lo = cfg_wr && !paddr[pae_pkg::CFG_HALF_BIT];
  assign cfg_bus.we_hi = cfg_wr && paddr[pae_pkg::CFG_HALF_BIT];
  assign cfg_bus.waddr = cfg_idx(paddr);
  assign cfg_bus.wdata = pwdata;
  assign cfg_bus.raddr = (st_r == pae_pkg::PAE_ST_FETCH) ? ch_r
                                                        : cfg_idx(paddr);

  // Halves never written read as zero, so a fresh entry is type off.
  assign cfg = {whi_r[sel_idx] ? cfg_bus.rdata[pae_pkg::CFGW-1:DW] : 32'h0,
                wlo_r[sel_idx] ? cfg_bus.rdata[DW-1:0] : 32'h0};

  // Acknowledge from the pins reaches every channel; the bus acks by bit.
  assign ack_now = {NCH{pin_ack_r}} |
                   ((bus_commit && paddr == pae_pkg::ADDR_ACK) ?
                    pwdata[NCH-1:0] : '0);

  // Manual reset accepts an ack only once the condition is seen gone.
  assign cap_ok = out_r & (~man_r | ~cdel_r);

  //////////////////////////////////////////////////////////////////////////
  // Sequencer: one evaluation pass over all channels per sample.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= pae_pkg::PAE_ST_IDLE;
      ch_r <= '0;
    end else begin
      case (st_r)
        pae_pkg::PAE_ST_IDLE: begin
          if (psel && penable) begin
            st_r <= pae_pkg::PAE_ST_BRD;
          end else if (sample_pend_r) begin
            st_r <= pae_pkg::PAE_ST_FETCH;
            ch_r <= '0;
          end
        end
        pae_pkg::PAE_ST_FETCH: st_r <= pae_pkg::PAE_ST_EVAL;
        pae_pkg::PAE_ST_EVAL: begin
          if (ch_r == CHW'(NCH - 1)) begin
            st_r <= pae_pkg::PAE_ST_IDLE;
          end else begin
            ch_r <= ch_r + CHW'(1);
            st_r <= pae_pkg::PAE_ST_FETCH;
          end
        end
        pae_pkg::PAE_ST_BRD:  st_r <= pae_pkg::PAE_ST_BACK;
        pae_pkg::PAE_ST_BACK: st_r <= pae_pkg::PAE_ST_IDLE;
        default:              st_r <= pae_pkg::PAE_ST_IDLE;
      endcase
    end
  end

  // A strobe during a pass or a bus access waits; strobes merge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_pend_r <= 1'b0;
    end else if (sample_strobe) begin
      sample_pend_r <= 1'b1;
    end else if (st_r == pae_pkg::PAE_ST_IDLE && !(psel && penable)) begin
      sample_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      span_r <= '0;
    end else if (st_eval && ch_r == CHW'(NCH - 1)) begin
      span_r <= span_r + pae_pkg::SPAN_W'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Evaluation of the channel in ch_r.

  pae_pkg::pae_type_t   typ;
  pae_pkg::pae_latch_t  lmode;
  logic signed [XW-1:0] v;
  logic signed [XW-1:0] r;
  logic signed [XW-1:0] thr;
  logic signed [XW-1:0] hy;
  logic signed [XW-1:0] dev;
  logic signed [XW-1:0] absdev;
  logic signed [XW-1:0] rate;
  logic                 span_last;
  logic                 blk;
  logic                 raw_nxt;
  logic                 qual;
  logic                 armed_nxt;
  logic [VW-1:0]        cnt_nxt;
  logic                 cdel_nxt;
  logic                 ackp;
  logic                 out_nxt;
  logic                 pend_nxt;

  always_comb begin
    typ   = pae_pkg::pae_type_t'(cfg[pae_pkg::TYPE_LSB +: pae_pkg::TYPE_W]);
    lmode = pae_pkg::pae_latch_t'(cfg[pae_pkg::LATCH_LSB +: pae_pkg::LATCH_W]);
    blk   = cfg[pae_pkg::BLOCK_BIT];
    thr   = sext(cfg[pae_pkg::THR_LSB +: VW]);
    hy    = $signed({{(XW-VW){1'b0}}, cfg[pae_pkg::HYST_LSB +: VW]});
    v     = sext(measured_process_value[ch_r*VW +: VW]);
    // User channels wire their second input here, so dev is A minus B.
    r     = sext(reference_value[ch_r*VW +: VW]);
    dev   = v - r;
    absdev = (dev < 0) ? -dev : dev;
    span_last = (span_r == pae_pkg::RATE_SPAN_LAST);
    // Rate spans several samples, which delays detection a little.
    rate  = span_last ? (v - sext(snap_r[ch_r])) : rate_r[ch_r];
    case (typ)
      pae_pkg::PAE_FS_HIGH:  raw_nxt = above(v, thr, hy, raw_r[ch_r]);
      pae_pkg::PAE_FS_LOW:   raw_nxt = above(-v, -thr, hy, raw_r[ch_r]);
      pae_pkg::PAE_DEV_HIGH: raw_nxt = above(dev, thr, hy, raw_r[ch_r]);
      pae_pkg::PAE_DEV_LOW:  raw_nxt = above(-dev, thr, hy, raw_r[ch_r]);
      pae_pkg::PAE_DEV_BAND: raw_nxt = above(absdev, thr, hy,
                                             raw_r[ch_r]);
      pae_pkg::PAE_ROC_NEG:  raw_nxt = above(-rate, thr, hy,
                                             raw_r[ch_r]);
      pae_pkg::PAE_ROC_POS:  raw_nxt = above(rate, thr, hy,
                                             raw_r[ch_r]);
      default:               raw_nxt = 1'b0;
    endcase
    // The pass that first sees the safe state arms; it never alarms itself.
    armed_nxt = armed_r[ch_r] | ~raw_nxt;
    qual      = raw_nxt & (armed_r[ch_r] | ~blk);
    if (!qual) begin
      cnt_nxt = '0;
    end else if (&cnt_r[ch_r]) begin
      cnt_nxt = cnt_r[ch_r];
    end else begin
      cnt_nxt = cnt_r[ch_r] + VW'(1);
    end
    cdel_nxt = qual && (cnt_r[ch_r] >= cfg[pae_pkg::DELAY_LSB +: VW]);
    ackp     = pend_r[ch_r] | (ack_now[ch_r] & cap_ok[ch_r]);
    case (lmode)
      pae_pkg::PAE_LATCH_AUTO,
      pae_pkg::PAE_LATCH_MANUAL: begin
        out_nxt = cdel_nxt | (out_r[ch_r] & ~ackp);
      end
      default: out_nxt = cdel_nxt;
    endcase
    // Only auto reset keeps an ack taken while the condition stands.
    pend_nxt = (lmode == pae_pkg::PAE_LATCH_AUTO) && out_nxt && ackp;
    if (!enable_r[ch_r]) begin
      raw_nxt   = 1'b0;
      armed_nxt = 1'b0;
      cnt_nxt   = '0;
      cdel_nxt  = 1'b0;
      out_nxt   = 1'b0;
      pend_nxt  = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Per-channel alarm state.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_r   <= '0;
      armed_r <= '0;
      cdel_r  <= '0;
      out_r   <= '0;
      man_r   <= '0;
    end else if (st_eval) begin
      raw_r[ch_r]   <= raw_nxt;
      armed_r[ch_r] <= armed_nxt;
      cdel_r[ch_r]  <= cdel_nxt;
      out_r[ch_r]   <= out_nxt;
      man_r[ch_r]   <= (lmode == pae_pkg::PAE_LATCH_MANUAL);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_chan
      // An ack landing in the channel's own pass is folded into pend_nxt.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pend_r[gi] <= 1'b0;
        end else if (st_eval && ch_r == CHW'(gi)) begin
          pend_r[gi] <= pend_nxt;
        end else if (ack_now[gi] && cap_ok[gi]) begin
          pend_r[gi] <= 1'b1;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_r[gi]  <= '0;
          snap_r[gi] <= '0;
          rate_r[gi] <= '0;
        end else if (st_eval && ch_r == CHW'(gi)) begin
          cnt_r[gi] <= cnt_nxt;
          if (span_last) begin
            snap_r[gi] <= measured_process_value[gi*VW +: VW];
            rate_r[gi] <= rate;
          end
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Acknowledge pins: three stages, a level counts once the last two stages agree.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= {ack_input, ack_button};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_r    <= '0;
      pin_ack_r <= 1'b0;
    end else begin
      filt_r    <= (sync2_r & sync3_r) | (filt_r & (sync2_r | sync3_r));
      pin_ack_r <= |(sync2_r & sync3_r & ~filt_r);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Software registers.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r <= pae_pkg::ENABLE_RST;
    end else if (bus_commit && paddr == pae_pkg::ADDR_ENABLE) begin
      enable_r <= pwdata[NCH-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wlo_r <= '0;
      whi_r <= '0;
    end else begin
      if (cfg_bus.we_lo) begin
        wlo_r[cfg_bus.waddr] <= 1'b1;
      end
      if (cfg_bus.we_hi) begin
        whi_r[cfg_bus.waddr] <= 1'b1;
      end
    end
  end

  // Answer is prepared in the read state, one cycle after the access
  // phase is seen, so the configuration memory has settled by then.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (st_r == pae_pkg::PAE_ST_BRD) begin
      pready_r  <= 1'b1;
      pslverr_r <= !addr_ok(paddr);
      if (!addr_ok(paddr) || pwrite) begin
        prdata_r <= '0;
      end else if (is_cfg(paddr)) begin
        prdata_r <= paddr[pae_pkg::CFG_HALF_BIT] ?
                    cfg[pae_pkg::CFGW-1:DW] : cfg[DW-1:0];
      end else begin
        case (paddr)
          pae_pkg::ADDR_ENABLE: prdata_r <= zext(enable_r);
          pae_pkg::ADDR_STATUS: prdata_r <= zext(out_r);
          pae_pkg::ADDR_COND:   prdata_r <= zext(cdel_r);
          pae_pkg::ADDR_ARMED:  prdata_r <= zext(armed_r);
          default:              prdata_r <= '0;
        endcase
      end
    end else begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end
  end

  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign alarm_out = out_r;

endmodule : pae_top
`default_nettype wire
